// [cbrcd_decoder.sv]
// command decoder for the basic, stream read and block read classes
// Notes on behaviour
// - reserved indices framed 48 bits, no reply
// - index 0 returns to idle, no reply
// - idle card answers condition query with register
// - identity broadcast gives long identity reply
// - address command adopts upper argument half
// - driver command loads upper half, no reply
// - select moves stand-by/transfer, programming/disconnect
// - own address selects, others deselect, zero all
// - addressed specific data gives long reply
// - addressed identity request gives long reply
// - stream read runs from address until stop
// - stop ends transfer, short reply
// - addressed status request gives short reply
// - addressed go-inactive enters inactive, no reply
// - block length command sets later block size
// - single read moves one block of length
// - multiple read runs until stop or a new multiple read
// - don't-care argument bits have no effect
// - data addresses are full 32-bit byte addresses
// - frame is 48 bits, checked, msb first
// - undefined, unsupported or misplaced commands are illegal, except in the inactive state
`timescale 1ns/1ns
module cbrcd_decoder (
    // core clock and reset
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    // card bus clock and command line from the host
    input wire logic LINK_CLK,
    input wire logic CMD_LINE,
    // completion of a single block from the data line logic
    input wire logic XFER_DONE,
    // response request to the formatter
    output logic RESP_VALID,
    output cbrcd_pkg::cbrcd_resp_t RESP,
    // card state and registers
    output cbrcd_pkg::cbrcd_state_t CARD_STATE,
    output logic [15:0] CARD_RCA,
    output logic [15:0] CARD_DSR,
    output logic [31:0] BLOCK_LEN,
    output logic ILLEGAL_CMD,
    output logic ILLEGAL_SEEN,
    // read transfer control
    output logic XFER_START,
    output logic XFER_STOP,
    output cbrcd_pkg::cbrcd_xfer_t XFER
);

    // link domain: frame capture
    logic lrst_s1;
    logic lrst;
    logic in_frame;
    logic [5:0] bit_cnt;
    logic [cbrcd_pkg::SHREG_W-1:0] shreg;
    logic [6:0] crc;
    logic frame_tog;
    cbrcd_pkg::cbrcd_cmd_t frame_hold;

    wire crc_fb = CMD_LINE ^ crc[6];
    wire [6:0] crc_step = {crc[5:0], 1'b0} ^ (crc_fb ? cbrcd_pkg::CRC_POLY : 7'h00);
    wire frame_start = !in_frame && !CMD_LINE;
    wire frame_end = in_frame && (bit_cnt == cbrcd_pkg::FRAME_LAST_BIT);
    wire frame_good = frame_end && CMD_LINE && shreg[cbrcd_pkg::TX_BIT] && (shreg[6:0] == crc);
    wire [6:0] next_crc = (bit_cnt <= cbrcd_pkg::CRC_LAST_BIT) ? crc_step : crc;

    always_ff @(posedge LINK_CLK)
    begin
        lrst_s1 <= SYS_RST;
        lrst <= lrst_s1;
    end

    always_ff @(posedge LINK_CLK)
    begin
        if (lrst)
        begin
            in_frame <= 1'b0;
            bit_cnt <= 6'h00;
            crc <= 7'h00;
        end
        else if (frame_start)
        begin
            in_frame <= 1'b1;
            bit_cnt <= cbrcd_pkg::FIRST_BODY_BIT;
            crc <= 7'h00;
        end
        else if (frame_end)
            in_frame <= 1'b0;
        else if (in_frame)
        begin
            bit_cnt <= bit_cnt + 6'h01;
            crc <= next_crc;
        end
    end

    always_ff @(posedge LINK_CLK)
    begin
        if (in_frame && !frame_end)
            shreg <= {shreg[cbrcd_pkg::SHREG_W-2:0], CMD_LINE};
    end

    // whole checked frames only; reserved indices pass as full frames too
    always_ff @(posedge LINK_CLK)
    begin
        if (lrst)
        begin
            frame_tog <= 1'b0;
            frame_hold <= '0;
        end
        else if (frame_good)
        begin
            frame_tog <= !frame_tog;
            frame_hold <= shreg[cbrcd_pkg::TX_BIT-1:7];
        end
    end

    // core domain: toggle crossing
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;

    always_ff @(posedge CORE_CLK)
    begin
        tog_s1 <= frame_tog;
        tog_s2 <= tog_s1;
        tog_s3 <= tog_s2;
    end

    // held word is stable for a whole frame after the toggle
    wire cmd_ok = (tog_s2 ^ tog_s3) && !SYS_RST;
    wire cbrcd_pkg::cbrcd_cmd_t cmd = frame_hold;
    wire [15:0] arg_rca = cmd.arg[31:16];
    wire match = (arg_rca == CARD_RCA) && (arg_rca != cbrcd_pkg::RCA_NONE);

    // index decode
    wire is_idle = cmd.index == cbrcd_pkg::CMD_GO_IDLE;
    wire is_op = cmd.index == cbrcd_pkg::CMD_QUERY_OP;
    wire is_all_id = cmd.index == cbrcd_pkg::CMD_ALL_IDENTITY;
    wire is_rca = cmd.index == cbrcd_pkg::CMD_SET_ADDR;
    wire is_dsr = cmd.index == cbrcd_pkg::CMD_SET_DRIVER;
    wire is_sel = cmd.index == cbrcd_pkg::CMD_SELECT;
    wire is_csd = cmd.index == cbrcd_pkg::CMD_SPECIFIC;
    wire is_cid = cmd.index == cbrcd_pkg::CMD_IDENTITY;
    wire is_stream = cmd.index == cbrcd_pkg::CMD_STREAM_READ;
    wire is_stop = cmd.index == cbrcd_pkg::CMD_STOP;
    wire is_status = cmd.index == cbrcd_pkg::CMD_STATUS;
    wire is_inact = cmd.index == cbrcd_pkg::CMD_INACTIVE;
    wire is_blen = cmd.index == cbrcd_pkg::CMD_BLOCK_LEN;
    wire is_single = cmd.index == cbrcd_pkg::CMD_READ_SINGLE;
    wire is_multi = cmd.index == cbrcd_pkg::CMD_READ_MULTI;

    // state groups
    wire st_stby = CARD_STATE == cbrcd_pkg::ST_STBY;
    wire st_tran = CARD_STATE == cbrcd_pkg::ST_TRAN;
    wire st_data = CARD_STATE == cbrcd_pkg::ST_DATA;
    wire st_ina = CARD_STATE == cbrcd_pkg::ST_INA;
    wire st_addr = st_stby || st_tran || st_data
        || CARD_STATE == cbrcd_pkg::ST_PRG || CARD_STATE == cbrcd_pkg::ST_DIS;

    // accepted commands
    wire go_idle = cmd_ok && is_idle;
    wire acc_op = cmd_ok && is_op && CARD_STATE == cbrcd_pkg::ST_IDLE;
    wire acc_all_id = cmd_ok && is_all_id && CARD_STATE == cbrcd_pkg::ST_READY;
    wire acc_rca = cmd_ok && is_rca && CARD_STATE == cbrcd_pkg::ST_IDENT;
    wire acc_dsr = cmd_ok && is_dsr && st_stby;
    wire acc_sel = cmd_ok && is_sel && st_addr;
    wire sel_hit = acc_sel && match;
    wire sel_miss = acc_sel && !match;
    wire acc_csd = cmd_ok && is_csd && st_stby && match;
    wire acc_cid = cmd_ok && is_cid && st_stby && match;
    wire acc_stream = cmd_ok && is_stream && st_tran;
    wire acc_stop = cmd_ok && is_stop && st_data;
    wire acc_status = cmd_ok && is_status && st_addr && match;
    wire acc_inact = cmd_ok && is_inact && st_addr && match;
    wire acc_blen = cmd_ok && is_blen && st_tran;
    wire acc_single = cmd_ok && is_single && st_tran;
    wire acc_multi = cmd_ok && is_multi && (st_tran || st_data);
    wire quiet = cmd_ok && (is_csd || is_cid || is_status || is_inact) && st_addr && !match;
    wire acc_any = go_idle || acc_op || acc_all_id || acc_rca || acc_dsr || acc_sel || acc_csd
        || acc_cid || acc_stream || acc_stop || acc_status || acc_inact || acc_blen || acc_single || acc_multi;
    wire illegal = cmd_ok && !acc_any && !quiet && !st_ina;
    wire start_any = acc_stream || acc_single || acc_multi;
    wire single_done = st_data && XFER_DONE && XFER.mode == cbrcd_pkg::XM_SINGLE;

    // responses
    wire next_resp_valid = acc_op || acc_all_id || acc_rca || sel_hit || acc_csd || acc_cid
        || acc_stream || acc_stop || acc_status || acc_blen || acc_single || acc_multi;
    wire cbrcd_pkg::cbrcd_resp_kind_t next_kind = acc_op ? cbrcd_pkg::RESP_OP
        : (acc_all_id || acc_cid) ? cbrcd_pkg::RESP_LONG_CID
        : acc_csd ? cbrcd_pkg::RESP_LONG_CSD : cbrcd_pkg::RESP_SHORT;
    wire cbrcd_pkg::cbrcd_resp_t next_resp = '{kind: next_kind, index: cmd.index};
    wire cbrcd_pkg::cbrcd_resp_t next_valid_resp = next_resp_valid ? next_resp : RESP;

    // transfer control; arguments taken whole as byte addresses
    wire cbrcd_pkg::cbrcd_xfer_mode_t start_mode = acc_stream ? cbrcd_pkg::XM_STREAM
        : acc_single ? cbrcd_pkg::XM_SINGLE : cbrcd_pkg::XM_MULTI;
    wire end_xfer = acc_stop || single_done || go_idle || sel_miss || acc_inact;
    wire cbrcd_pkg::cbrcd_xfer_t start_xfer = '{mode: start_mode, addr: cmd.arg};
    wire cbrcd_pkg::cbrcd_xfer_t idle_xfer = '{mode: cbrcd_pkg::XM_NONE, addr: XFER.addr};
    wire cbrcd_pkg::cbrcd_xfer_t next_xfer = start_any ? start_xfer : end_xfer ? idle_xfer : XFER;
    wire next_stop = acc_stop || (st_data && (go_idle || sel_miss || acc_inact));

    // card registers; low argument halves never reach address or driver stage, block length takes the whole argument
    wire [15:0] next_rca = go_idle ? cbrcd_pkg::RCA_RESET : acc_rca ? arg_rca : CARD_RCA;
    wire [15:0] next_dsr = acc_dsr ? arg_rca : CARD_DSR;
    wire [31:0] next_blen = acc_blen ? cmd.arg : BLOCK_LEN;
    wire next_seen = illegal || (ILLEGAL_SEEN && !acc_status);

    cbrcd_pkg::cbrcd_state_t next_state;

    always_comb
    begin
        next_state = CARD_STATE;
        unique case (CARD_STATE)
            cbrcd_pkg::ST_IDLE: if (acc_op) next_state = cbrcd_pkg::ST_READY;
            cbrcd_pkg::ST_READY: if (acc_all_id) next_state = cbrcd_pkg::ST_IDENT;
            cbrcd_pkg::ST_IDENT: if (acc_rca) next_state = cbrcd_pkg::ST_STBY;
            cbrcd_pkg::ST_STBY: if (sel_hit) next_state = cbrcd_pkg::ST_TRAN;
            cbrcd_pkg::ST_TRAN:
                if (sel_miss) next_state = cbrcd_pkg::ST_STBY;
                else if (start_any) next_state = cbrcd_pkg::ST_DATA;
            cbrcd_pkg::ST_DATA:
                if (sel_miss) next_state = cbrcd_pkg::ST_STBY;
                else if (acc_stop || (single_done && !start_any)) next_state = cbrcd_pkg::ST_TRAN;
            cbrcd_pkg::ST_PRG: if (sel_miss) next_state = cbrcd_pkg::ST_DIS;
            cbrcd_pkg::ST_DIS: if (sel_hit) next_state = cbrcd_pkg::ST_PRG;
            cbrcd_pkg::ST_INA: next_state = cbrcd_pkg::ST_INA;
        endcase
        if (acc_inact)
            next_state = cbrcd_pkg::ST_INA;
        if (go_idle)
            next_state = cbrcd_pkg::ST_IDLE;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            CARD_STATE <= cbrcd_pkg::ST_IDLE;
            CARD_RCA <= cbrcd_pkg::RCA_RESET;
            CARD_DSR <= cbrcd_pkg::DSR_RESET;
            BLOCK_LEN <= cbrcd_pkg::BLOCK_LEN_RESET;
            ILLEGAL_SEEN <= 1'b0;
            XFER <= '{mode: cbrcd_pkg::XM_NONE, addr: 32'h0000_0000};
        end
        else
        begin
            CARD_STATE <= next_state;
            CARD_RCA <= next_rca;
            CARD_DSR <= next_dsr;
            BLOCK_LEN <= next_blen;
            ILLEGAL_SEEN <= next_seen;
            XFER <= next_xfer;
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            RESP_VALID <= 1'b0;
            RESP <= '{kind: cbrcd_pkg::RESP_SHORT, index: 6'h00};
            ILLEGAL_CMD <= 1'b0;
            XFER_START <= 1'b0;
            XFER_STOP <= 1'b0;
        end
        else
        begin
            RESP_VALID <= next_resp_valid;
            RESP <= next_valid_resp;
            ILLEGAL_CMD <= illegal;
            XFER_START <= start_any;
            XFER_STOP <= next_stop;
        end
    end

    // checks in the core domain, frame close check on the card bus clock
    default clocking cc @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);

    a_go_idle_reset: assert property (go_idle |=> CARD_STATE == cbrcd_pkg::ST_IDLE && !RESP_VALID)
        else $error("reset command did not return quietly to idle");
    a_op_cond_reply: assert property (acc_op |=> RESP_VALID && RESP.kind == cbrcd_pkg::RESP_OP
        && CARD_STATE == cbrcd_pkg::ST_READY)
        else $error("condition query not answered");
    a_identity_long: assert property (acc_all_id |=> RESP_VALID && RESP.kind == cbrcd_pkg::RESP_LONG_CID)
        else $error("identity broadcast not answered long");
    a_rca_adopt: assert property (acc_rca |=> CARD_RCA == $past(cmd.arg[31:16])
        && RESP.kind == cbrcd_pkg::RESP_SHORT && CARD_STATE == cbrcd_pkg::ST_STBY)
        else $error("relative address not adopted");
    a_dsr_load: assert property (acc_dsr |=> CARD_DSR == $past(cmd.arg[31:16]) && !RESP_VALID)
        else $error("driver stage not loaded quietly");
    a_select_enter: assert property (cmd_ok && is_sel && st_stby && match
        |=> CARD_STATE == cbrcd_pkg::ST_TRAN && RESP_VALID)
        else $error("selection did not reach transfer");
    a_deselect_quiet: assert property (cmd_ok && is_sel && !match |=> !RESP_VALID)
        else $error("deselected card answered");
    a_specific_data: assert property (acc_csd |=> RESP_VALID && RESP.kind == cbrcd_pkg::RESP_LONG_CSD)
        else $error("specific data not answered long");
    a_addr_quiet: assert property (quiet |=> !RESP_VALID && $stable(CARD_STATE) && !ILLEGAL_CMD)
        else $error("card acted on a foreign address");
    a_stream_run: assert property (acc_stream |=> XFER_START && XFER.mode == cbrcd_pkg::XM_STREAM
        && XFER.addr == $past(cmd.arg) ##1 !XFER_START)
        else $error("stream read not started at address");
    a_stop_end: assert property (acc_stop |=> XFER_STOP && RESP_VALID
        && CARD_STATE == cbrcd_pkg::ST_TRAN && XFER.mode == cbrcd_pkg::XM_NONE)
        else $error("stop did not end the transfer");
    a_status_short: assert property (acc_status |=> RESP_VALID && RESP.kind == cbrcd_pkg::RESP_SHORT
        && !ILLEGAL_SEEN)
        else $error("status request not answered");
    a_inactive_enter: assert property (acc_inact |=> CARD_STATE == cbrcd_pkg::ST_INA && !RESP_VALID)
        else $error("go inactive failed");
    a_block_len: assert property (acc_blen |=> BLOCK_LEN == $past(cmd.arg) && RESP_VALID)
        else $error("block length not set");
    a_single_block: assert property (st_data && XFER.mode == cbrcd_pkg::XM_SINGLE && XFER_DONE && !cmd_ok
        |=> CARD_STATE == cbrcd_pkg::ST_TRAN && XFER.mode == cbrcd_pkg::XM_NONE)
        else $error("single block read did not finish");
    a_multi_block: assert property (st_data && XFER.mode == cbrcd_pkg::XM_MULTI && XFER_DONE && !cmd_ok
        |=> CARD_STATE == cbrcd_pkg::ST_DATA && XFER.mode == cbrcd_pkg::XM_MULTI)
        else $error("multiple block read stopped by itself");
    a_illegal_flag: assert property (illegal |=> ILLEGAL_CMD && ILLEGAL_SEEN && !RESP_VALID)
        else $error("illegal command not flagged");
    a_identity_addr: assert property (acc_cid |=> RESP_VALID && RESP.kind == cbrcd_pkg::RESP_LONG_CID)
        else $error("addressed identity not answered long");
    a_deselect_end: assert property (cmd_ok && is_sel && !match && st_data
        |=> CARD_STATE == cbrcd_pkg::ST_STBY && XFER_STOP && XFER.mode == cbrcd_pkg::XM_NONE)
        else $error("deselection did not end the transfer");
    a_inactive_mute: assert property (cmd_ok && st_ina && !is_idle
        |=> CARD_STATE == cbrcd_pkg::ST_INA && !RESP_VALID && !ILLEGAL_CMD)
        else $error("inactive card reacted");
    a_frame_close: assert property (@(posedge LINK_CLK) disable iff (lrst)
        frame_end |=> !in_frame && bit_cnt == cbrcd_pkg::FRAME_LAST_BIT)
        else $error("frame not closed at the end bit");

    c_select: cover property (sel_hit);
    c_stream_stop: cover property (acc_stream ##[1:1000] acc_stop);
    c_single: cover property (acc_single ##[1:1000] single_done);
    c_illegal: cover property (illegal);
    c_multi_restart: cover property (acc_multi && st_data);

endmodule

// [cbrcd_host_model.sv]
// host model: card bus clock and command frames
`timescale 1ns/1ns
module cbrcd_host_model (
    // card bus clock and command line
    output logic LINK_CLK,
    output logic CMD_LINE
);
    localparam int HALF = 80;

    // clock stands low, line idles high
    initial
    begin
        LINK_CLK = 1'b0;
        CMD_LINE = 1'b1;
    end

    // check code over the first 40 frame bits
    function automatic logic [6:0] crc7(input logic [39:0] body);
        logic [6:0] c;
        logic fb;
        c = 7'h00;
        for (int i = 39; i >= 0; i--)
        begin
            fb = c[6] ^ body[i];
            c = {c[5:0], 1'b0};
            if (fb)
                c = c ^ 7'h09;
        end
        return c;
    endfunction

    // clock pulses with the line idle
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++)
        begin
            #HALF LINK_CLK = 1'b1;
            #HALF LINK_CLK = 1'b0;
        end
    endtask

    // one full frame, msb first, every argument bit sent; flip corrupts the check code
    task automatic send_frame(input logic [5:0] idx, input logic [31:0] arg, input logic [6:0] flip);
        logic [47:0] frame;
        frame = {2'b01, idx, arg, crc7({2'b01, idx, arg}) ^ flip, 1'b1};
        #7;
        for (int i = 47; i >= 0; i--)
        begin
            CMD_LINE = frame[i];
            #HALF LINK_CLK = 1'b1;
            #HALF LINK_CLK = 1'b0;
        end
        CMD_LINE = 1'b1;
        idle_clocks(2);
    endtask
endmodule

// [cbrcd_pkg.sv]
// constants and types for the card basic and read command decoder
package cbrcd_pkg;

    // card states
    typedef enum logic [3:0] {
        ST_IDLE, ST_READY, ST_IDENT, ST_STBY, ST_TRAN, ST_DATA, ST_PRG, ST_DIS, ST_INA
    } cbrcd_state_t;

    // kind of answer the response formatter must send
    typedef enum logic [1:0] {
        RESP_SHORT, RESP_LONG_CID, RESP_LONG_CSD, RESP_OP
    } cbrcd_resp_kind_t;

    // kind of read transfer handed to the data line logic
    typedef enum logic [1:0] {
        XM_NONE, XM_STREAM, XM_SINGLE, XM_MULTI
    } cbrcd_xfer_mode_t;

    typedef struct packed {
        logic [5:0] index;
        logic [31:0] arg;
    } cbrcd_cmd_t;

    typedef struct packed {
        cbrcd_resp_kind_t kind;
        logic [5:0] index;
    } cbrcd_resp_t;

    typedef struct packed {
        cbrcd_xfer_mode_t mode;
        logic [31:0] addr;
    } cbrcd_xfer_t;

    // command indices
    localparam logic [5:0] CMD_GO_IDLE = 6'h00;
    localparam logic [5:0] CMD_QUERY_OP = 6'h01;
    localparam logic [5:0] CMD_ALL_IDENTITY = 6'h02;
    localparam logic [5:0] CMD_SET_ADDR = 6'h03;
    localparam logic [5:0] CMD_SET_DRIVER = 6'h04;
    localparam logic [5:0] CMD_SELECT = 6'h07;
    localparam logic [5:0] CMD_SPECIFIC = 6'h09;
    localparam logic [5:0] CMD_IDENTITY = 6'h0A;
    localparam logic [5:0] CMD_STREAM_READ = 6'h0B;
    localparam logic [5:0] CMD_STOP = 6'h0C;
    localparam logic [5:0] CMD_STATUS = 6'h0D;
    localparam logic [5:0] CMD_INACTIVE = 6'h0F;
    localparam logic [5:0] CMD_BLOCK_LEN = 6'h10;
    localparam logic [5:0] CMD_READ_SINGLE = 6'h11;
    localparam logic [5:0] CMD_READ_MULTI = 6'h12;

    // frame layout, counted from the start bit at zero
    localparam logic [5:0] FRAME_LAST_BIT = 6'h2F;
    localparam logic [5:0] CRC_LAST_BIT = 6'h27;
    localparam logic [5:0] FIRST_BODY_BIT = 6'h01;
    localparam int SHREG_W = 46;
    localparam int TX_BIT = 45;
    localparam logic [6:0] CRC_POLY = 7'h09;

    // reset values
    localparam logic [15:0] RCA_RESET = 16'h0000;
    localparam logic [15:0] DSR_RESET = 16'h0000;
    localparam logic [31:0] BLOCK_LEN_RESET = 32'h0000_0200;
    localparam logic [15:0] RCA_NONE = 16'h0000;

endpackage

// [testbench.sv]
// self-checking bench for the command decoder
`timescale 1ns/1ns
module testbench;
    logic CORE_CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic XFER_DONE = 1'b0;
    logic LINK_CLK;
    logic CMD_LINE;
    logic RESP_VALID;
    cbrcd_pkg::cbrcd_resp_t RESP;
    cbrcd_pkg::cbrcd_state_t CARD_STATE;
    logic [15:0] CARD_RCA;
    logic [15:0] CARD_DSR;
    logic [31:0] BLOCK_LEN;
    logic ILLEGAL_CMD;
    logic ILLEGAL_SEEN;
    logic XFER_START;
    logic XFER_STOP;
    cbrcd_pkg::cbrcd_xfer_t XFER;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    int n_resp = 0;
    int n_ill = 0;
    int n_start = 0;
    int n_stop = 0;
    cbrcd_pkg::cbrcd_resp_t last_resp;
    logic [31:0] seed = 32'h4435441A;
    logic [15:0] relative_card_address;

    always #10 CORE_CLK = ~CORE_CLK;

    cbrcd_host_model host_model_inst (.LINK_CLK(LINK_CLK), .CMD_LINE(CMD_LINE));

    cbrcd_decoder cbrcd_decoder_inst (
        .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .LINK_CLK(LINK_CLK), .CMD_LINE(CMD_LINE),
        .XFER_DONE(XFER_DONE), .RESP_VALID(RESP_VALID), .RESP(RESP), .CARD_STATE(CARD_STATE),
        .CARD_RCA(CARD_RCA), .CARD_DSR(CARD_DSR), .BLOCK_LEN(BLOCK_LEN), .ILLEGAL_CMD(ILLEGAL_CMD),
        .ILLEGAL_SEEN(ILLEGAL_SEEN), .XFER_START(XFER_START), .XFER_STOP(XFER_STOP), .XFER(XFER)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic give_verdict();
        $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // pulse monitor and run limit
    always @(posedge CORE_CLK)
    begin
        cycles++;
        if (RESP_VALID === 1'b1)
        begin
            n_resp++;
            last_resp = RESP;
        end
        if (ILLEGAL_CMD === 1'b1)
            n_ill++;
        if (XFER_START === 1'b1)
            n_start++;
        if (XFER_STOP === 1'b1)
            n_stop++;
        if (cycles == 30000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic chk_vec(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_state(input cbrcd_pkg::cbrcd_state_t exp, input cbrcd_pkg::cbrcd_state_t got);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED card state expected %0d seen %0d", exp, got);
        end
    endtask

    task automatic chk_xfer(input cbrcd_pkg::cbrcd_xfer_mode_t m, input logic [31:0] a, input int ns, input int np);
        chk_vec("xfer mode", 32'(m), 32'(XFER.mode));
        chk_vec("xfer start count", ns, n_start);
        chk_vec("xfer stop count", np, n_stop);
        if (m != cbrcd_pkg::XM_NONE)
            chk_vec("xfer address", a, XFER.addr);
    endtask

    // one cycle of block completion from the data side
    task automatic pulse_done();
        @(posedge CORE_CLK);
        XFER_DONE <= 1'b1;
        @(posedge CORE_CLK);
        XFER_DONE <= 1'b0;
        repeat (4) @(posedge CORE_CLK);
    endtask

    // send one frame and compare answer, state and illegal pulses
    task automatic do_cmd(input logic [5:0] idx, input logic [31:0] a, input logic [6:0] flip, input int nr,
        input cbrcd_pkg::cbrcd_resp_kind_t k, input cbrcd_pkg::cbrcd_state_t st, input int ni);
        n_resp = 0;
        n_ill = 0;
        n_start = 0;
        n_stop = 0;
        host_model_inst.send_frame(idx, a, flip);
        repeat (8) @(posedge CORE_CLK);
        chk_vec("response count", nr, n_resp);
        if (nr > 0)
        begin
            chk_vec("response kind", 32'(k), 32'(last_resp.kind));
            chk_vec("response index", 32'(idx), 32'(last_resp.index));
        end
        chk_state(st, CARD_STATE);
        chk_vec("illegal count", ni, n_ill);
    endtask

    initial
    begin
        host_model_inst.idle_clocks(5);
        @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
        host_model_inst.idle_clocks(4);
        chk_state(cbrcd_pkg::ST_IDLE, CARD_STATE);
        chk_vec("rca", 32'h0, 32'(CARD_RCA));
        chk_vec("dsr", 32'h0, 32'(CARD_DSR));
        chk_vec("block length", 32'h200, BLOCK_LEN);
        chk_xfer(cbrcd_pkg::XM_NONE, 32'h0, 0, 0);
        seed = lfsr(seed);
        relative_card_address = seed[31:16] | 16'h0001;
        do_cmd(6'h01, seed, 7'h00, 1, cbrcd_pkg::RESP_OP, cbrcd_pkg::ST_READY, 0);
        do_cmd(6'h05, seed, 7'h00, 0, cbrcd_pkg::RESP_OP, cbrcd_pkg::ST_READY, 1);
        chk_vec("illegal seen", 32'h1, 32'(ILLEGAL_SEEN));
        do_cmd(6'h02, ~seed, 7'h00, 1, cbrcd_pkg::RESP_LONG_CID, cbrcd_pkg::ST_IDENT, 0);
        do_cmd(6'h03, {relative_card_address, seed[15:0]}, 7'h00, 1, cbrcd_pkg::RESP_SHORT, cbrcd_pkg::ST_STBY, 0);
        chk_vec("rca", 32'(relative_card_address), 32'(CARD_RCA));
        do_cmd(6'h04, ~seed, 7'h00, 0, cbrcd_pkg::RESP_OP, cbrcd_pkg::ST_STBY, 0);
        chk_vec("dsr", {16'h0000, ~seed[31:16]}, 32'(CARD_DSR));
        do_cmd(6'h09, {relative_card_address ^ 16'h0100, 16'h0}, 7'h00, 0, cbrcd_pkg::RESP_OP, cbrcd_pkg::ST_STBY, 0);
        do_cmd(6'h09, {relative_card_address, 16'hFFFF}, 7'h00, 1, cbrcd_pkg::RESP_LONG_CSD, cbrcd_pkg::ST_STBY, 0);
        do_cmd(6'h0A, {relative_card_address, 16'h0}, 7'h00, 1, cbrcd_pkg::RESP_LONG_CID, cbrcd_pkg::ST_STBY, 0);
        do_cmd(6'h0D, {relative_card_address, 16'h0}, 7'h01, 0, cbrcd_pkg::RESP_OP, cbrcd_pkg::ST_STBY, 0);
        chk_vec("illegal seen", 32'h1, 32'(ILLEGAL_SEEN));
        do_cmd(6'h0D, {relative_card_address, 16'h0}, 7'h00, 1, cbrcd_pkg::RESP_SHORT, cbrcd_pkg::ST_STBY, 0);
        chk_vec("illegal seen", 32'h0, 32'(ILLEGAL_SEEN));
        do_cmd(6'h07, {relative_card_address, 16'h0}, 7'h00, 1, cbrcd_pkg::RESP_SHORT, cbrcd_pkg::ST_TRAN, 0);
        do_cmd(6'h02, 32'h0, 7'h00, 0, cbrcd_pkg::RESP_OP, cbrcd_pkg::ST_TRAN, 1);
        seed = lfsr(seed);
        do_cmd(6'h10, seed, 7'h00, 1, cbrcd_pkg::RESP_SHORT, cbrcd_pkg::ST_TRAN, 0);
        chk_vec("block length", seed, BLOCK_LEN);
        seed = lfsr(seed);
        do_cmd(6'h0B, seed, 7'h00, 1, cbrcd_pkg::RESP_SHORT, cbrcd_pkg::ST_DATA, 0);
        chk_xfer(cbrcd_pkg::XM_STREAM, seed, 1, 0);
        do_cmd(6'h0C, ~seed, 7'h00, 1, cbrcd_pkg::RESP_SHORT, cbrcd_pkg::ST_TRAN, 0);
        chk_xfer(cbrcd_pkg::XM_NONE, seed, 0, 1);
        do_cmd(6'h11, 32'hFFFFFFFF, 7'h00, 1, cbrcd_pkg::RESP_SHORT, cbrcd_pkg::ST_DATA, 0);
        chk_xfer(cbrcd_pkg::XM_SINGLE, 32'hFFFFFFFF, 1, 0);
        pulse_done();
        chk_state(cbrcd_pkg::ST_TRAN, CARD_STATE);
        do_cmd(6'h12, 32'h0, 7'h00, 1, cbrcd_pkg::RESP_SHORT, cbrcd_pkg::ST_DATA, 0);
        chk_xfer(cbrcd_pkg::XM_MULTI, 32'h0, 1, 0);
        do_cmd(6'h12, seed, 7'h00, 1, cbrcd_pkg::RESP_SHORT, cbrcd_pkg::ST_DATA, 0);
        chk_vec("xfer start count", 1, n_start);
        chk_vec("xfer address", seed, XFER.addr);
        pulse_done();
        chk_state(cbrcd_pkg::ST_DATA, CARD_STATE);
        chk_vec("xfer mode", 32'(cbrcd_pkg::XM_MULTI), 32'(XFER.mode));
        do_cmd(6'h07, 32'h0000FFFF, 7'h00, 0, cbrcd_pkg::RESP_OP, cbrcd_pkg::ST_STBY, 0);
        chk_xfer(cbrcd_pkg::XM_NONE, 32'h0, 0, 1);
        do_cmd(6'h0F, {relative_card_address, 16'h0}, 7'h00, 0, cbrcd_pkg::RESP_OP, cbrcd_pkg::ST_INA, 0);
        do_cmd(6'h0D, {relative_card_address, 16'h0}, 7'h00, 0, cbrcd_pkg::RESP_OP, cbrcd_pkg::ST_INA, 0);
        do_cmd(6'h00, seed, 7'h00, 0, cbrcd_pkg::RESP_OP, cbrcd_pkg::ST_IDLE, 0);
        chk_vec("rca", 32'h0, 32'(CARD_RCA));
        for (int i = 0; i < 6; i++)
        begin
            seed = lfsr(seed);
            do_cmd(6'h02 + 6'(seed[7:0] % 62), seed, 7'h00, 0, cbrcd_pkg::RESP_OP, cbrcd_pkg::ST_IDLE, 1);
        end
        give_verdict();
    end
endmodule
